// *** sim/card_model.sv ***
// Purpose: behavioural card on the command line and on data line one
// Assumes: command bits change on LINK_CLK rising edges; lines are pulled up
// Notes:   replies with the bit vector handed in by the bench after a set delay
`timescale 1ns/1ns
module card_model
(
    // link side
    input  wire logic         link_clk,
    input  wire logic         cmd_out,
    input  wire logic         cmd_oe,
    output logic              cmd_in,
    output logic              data_line_one,
    // scenario control
    input  wire logic         long_resp,
    input  wire logic [7:0]   resp_delay,
    input  wire logic         irq_req,
    input  wire logic [135:0] resp_bits,
    output logic      [47:0]  got_frame,
    output int                frames
);
    logic [47:0] shift_ff;
    int          bit_cnt;
    int          low_bit;

    initial
    begin
        cmd_in = 1'b1;
        data_line_one = 1'b1;
        shift_ff = '0;
        got_frame = '0;
        bit_cnt = 0;
        frames = 0;
    end

    // -----------------------------------
    // capture one command, then reply
    // -----------------------------------
    always
    begin
        @(posedge link_clk);
        if (cmd_oe)
        begin
            shift_ff = {shift_ff[46:0], cmd_out};
            bit_cnt++;
        end
        else if (bit_cnt != 0)
        begin
            got_frame = shift_ff;
            bit_cnt = 0;
            low_bit = long_resp ? 0 : 88;
            // delay above the wait limit makes the host time out
            repeat (resp_delay) @(posedge link_clk);
            for (int i = 135; i >= low_bit; i--)
            begin
                cmd_in <= resp_bits[i];
                @(posedge link_clk);
            end
            // released line floats back to its pull-up
            cmd_in <= 1'b1;
            repeat (2) @(posedge link_clk);
            if (irq_req)
            begin
                data_line_one <= 1'b0;
                repeat (6) @(posedge link_clk);
                data_line_one <= 1'b1;
            end
            repeat (20) @(posedge link_clk);
            frames++;
        end
    end
endmodule : card_model

// *** sim/tb.sv ***
// Purpose: self-checking bench for the card command register bank
// Assumes: zero-wait APB slave; card model on the link
// Notes:   fifo byte events are driven as single-cycle pulses
`timescale 1ns/1ns
`include "card_cmd_map.svh"
module tb;
    logic         core_clk, link_clk, arst_n, psel, penable, pwrite, wide_bus, irq_req, long_resp;
    logic         rx_in, rx_out, tx_in, tx_out, err, cmd_out, cmd_oe, cmd_in, line_one, card_irq, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, arg;
    logic [7:0]   resp_delay;
    logic [135:0] resp_bits;
    logic [127:0] pay;
    logic [47:0]  got_frame;
    logic [5:0]   idx;
    int           frames, fail_count, checks_done, irq_hits, h0;

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    always @(posedge core_clk) if (card_irq === 1'b1) irq_hits++;

    card_cmd_regs dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_BYTE_IN(rx_in), .RX_BYTE_OUT(rx_out), .TX_BYTE_IN(tx_in), .TX_BYTE_OUT(tx_out),
        .WIDE_BUS(wide_bus), .LINK_CLK(link_clk), .CMD_IN(cmd_in), .CMD_OUT(cmd_out), .CMD_OE(cmd_oe),
        .CARD_DATA_LINE_ONE(line_one), .CARD_IRQ(card_irq));
    card_model card (.link_clk(link_clk), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .cmd_in(cmd_in),
        .data_line_one(line_one), .long_resp(long_resp), .resp_delay(resp_delay), .irq_req(irq_req),
        .resp_bits(resp_bits), .got_frame(got_frame), .frames(frames));

    // -----------------------------------
    // report and bus tasks
    // -----------------------------------
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : chk

    task automatic stall();
        fail_count++;
        test_done();
    endtask : stall

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) stall();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask : rdchk

    // one command with reply; waits for the card and for busy to clear
    task automatic issue(input logic [2:0] t, input logic data, input logic [7:0] dly);
        int n;
        int f0;
        pay = {arg, ~arg, arg ^ 32'h5a5a_5a5a, ~arg ^ 32'h0f0f_0f0f};
        long_resp <= (t == `RTYPE_R2);
        resp_delay <= dly;
        resp_bits <= (t == `RTYPE_R2) ? {2'b00, 6'h3f, pay} : {2'b00, idx, ~arg, 8'h01, 88'h0};
        apb(1'b1, `OFS_ARGUMENT, arg);
        f0 = frames;
        apb(1'b1, `OFS_COMMAND, {21'h0, t, 1'b0, data, idx});
        n = 0;
        while (frames == f0 && n < 5000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 5000) stall();
        for (n = 0; n < 100; n++)
        begin
            apb(1'b0, `OFS_LINK_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b0) break;
        end
        if (n >= 100) stall();
        chk("frame head", {24'h0, got_frame[47:40]}, {24'h0, 2'b01, idx});
        chk("frame argument", got_frame[39:8], arg);
    endtask : issue

    task automatic bytes(input logic [3:0] m);
        @(posedge core_clk);
        {rx_in, rx_out, tx_in, tx_out} <= m;
        @(posedge core_clk);
        {rx_in, rx_out, tx_in, tx_out} <= 4'h0;
    endtask : bytes

    // -----------------------------------
    // main sequence
    // -----------------------------------
    initial
    begin
        {arst_n, psel, penable, pwrite, wide_bus, irq_req, long_resp, rx_in, rx_out, tx_in, tx_out} = '0;
        {paddr, pwdata, resp_bits, resp_delay, arg, idx} = '0;
        fail_count = 0;
        checks_done = 0;
        irq_hits = 0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int a = `OFS_ARGUMENT; a <= `OFS_RESP_WORD3; a += 4)
            rdchk("reset word", a[11:0], 32'h0000_0000);
        rdchk("queue reset", `OFS_QUEUE_STATE, {24'h0, `TX_FREE_RESET});
        for (int t = 0; t < 4; t++)
        begin
            arg = 32'h1234_5670 + t * 32'h1111_1011;
            idx = 6'h2a ^ t[5:0];
            issue(t[2:0], 1'b0, 8'd2 + t[7:0] * 8'd10);
            rdchk("response index", `OFS_RESP_INDEX, {26'h0, (t >= 2) ? `IDX_ALL_ONES : idx});
            rdchk("word0", `OFS_RESP_WORD0, (t == 2) ? pay[39:8] : ~arg);
            rdchk("argument back", `OFS_ARGUMENT, arg);
            rdchk("command back", `OFS_COMMAND, {21'h0, t[2:0], 2'b00, idx});
            if (t == 2)
            begin
                rdchk("word1", `OFS_RESP_WORD1, pay[71:40]);
                rdchk("word2", `OFS_RESP_WORD2, pay[103:72]);
                rdchk("word3", `OFS_RESP_WORD3, {8'h00, pay[127:104]});
            end
        end
        // no reply within the wait limit keeps the last response
        arg = 32'hcafe_f00d;
        idx = 6'h05;
        issue(`RTYPE_R1, 1'b0, 8'd100);
        rdchk("index after timeout", `OFS_RESP_INDEX, {26'h0, `IDX_ALL_ONES});
        rdchk("word0 after timeout", `OFS_RESP_WORD0, ~(32'h1234_5670 + 3 * 32'h1111_1011));
        irq_req <= 1'b1;
        for (int c = 0; c < 3; c++)
        begin
            @(posedge core_clk);
            wide_bus <= (c != 2);
            h0 = irq_hits;
            issue(`RTYPE_R1, c == 1, 8'd4);
            chk("line one irq", {31'h0, irq_hits != h0}, {31'h0, c == 0});
        end
        repeat (5) bytes(4'b1000);
        repeat (3) bytes(4'b0010);
        rdchk("fifo fill", `OFS_QUEUE_STATE, 32'h0000_057d);
        bytes(4'b0101);
        bytes(4'b0100);
        apb(1'b1, `OFS_QUEUE_STATE, 32'h0000_0000);
        rdchk("purge zero", `OFS_QUEUE_STATE, 32'h0000_037e);
        apb(1'b1, `OFS_QUEUE_STATE, 32'h8000_0000);
        rdchk("rx purge", `OFS_QUEUE_STATE, 32'h0000_007e);
        apb(1'b1, `OFS_QUEUE_STATE, 32'h4000_0000);
        rdchk("tx purge", `OFS_QUEUE_STATE, 32'h0000_0080);
        // byte events on the very edge of a purge write: the purge must win
        bytes(4'b1000);
        fork
            apb(1'b1, `OFS_QUEUE_STATE, 32'hc000_0000);
            begin
                repeat (2) @(posedge core_clk);
                {rx_in, tx_in} <= 2'b11;
                @(posedge core_clk);
                {rx_in, tx_in} <= 2'b00;
            end
        join
        rdchk("purge beats byte", `OFS_QUEUE_STATE, 32'h0000_0080);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
        chk("unmapped data", rd, 32'h0000_0000);
        test_done();
    end
endmodule : tb

// *** verilog/card_cmd_map.svh ***
// Purpose: register offsets, field positions and reset values of the card command register bank
// Assumes: APB byte addresses equal the printed offsets
// Notes:   definitions only
`ifndef CARD_CMD_MAP_SVH
`define CARD_CMD_MAP_SVH
`define OFS_ARGUMENT        12'h018
`define OFS_COMMAND         12'h01c
`define OFS_RESP_INDEX      12'h020
`define OFS_RESP_WORD0      12'h024
`define OFS_RESP_WORD1      12'h028
`define OFS_RESP_WORD2      12'h02c
`define OFS_RESP_WORD3      12'h030
`define OFS_QUEUE_STATE     12'h034
`define OFS_LINK_STATUS     12'h03c
`define CMD_INDEX_MSB       5
`define CMD_DATA_BIT        6
`define CMD_RTYPE_LSB       8
`define CMD_RTYPE_MSB       10
`define RX_PURGE_BIT        31
`define TX_PURGE_BIT        30
`define TX_FREE_RESET       8'h80
`define IDX_ALL_ONES        6'h3f
`define RTYPE_R1            3'h0
`define RTYPE_R1B           3'h1
`define RTYPE_R2            3'h2
`define RTYPE_R3            3'h3
`define CMD_FRAME_BITS      8'h30
`define LONG_FRAME_BITS     8'h88
`define RESP_WAIT_BITS      8'h40
`define IRQ_WINDOW_BITS     8'h10
`endif

// *** verilog/card_cmd_pkg.sv ***
// Purpose: types shared by the card command register bank
// Assumes: nothing beyond the map header
// Notes:   one-hot link states
package card_cmd_pkg;
    typedef enum logic [4:0]
    {
        LINK_IDLE = 5'b0_0001,
        LINK_SEND = 5'b0_0010,
        LINK_WAIT = 5'b0_0100,
        LINK_RECV = 5'b0_1000,
        LINK_IRQW = 5'b1_0000
    } link_state_e;
endpackage : card_cmd_pkg

// *** verilog/card_cmd_regs.sv ***
// Behaviour
// - argument word sent with next command
// - argument reads back last written value
// - decode response kind R1 R1b R2 R3
// - sample data line one irq only in window
// - command write while link idle starts transfer with index
// - command reads back last written index
// - store received response index, reset zero
// - long and R3 responses report index ones
// - short responses fill only first word
// - long response bits spread over four words
// - rx purge write one empties receive count
// - tx purge write one refills transmit free count
// - report receive fifo fill bytes
// - report transmit fifo free bytes
//
// Purpose: APB register bank plus card command/response link engine
// Assumes: card link clocked by LINK_CLK; fifo byte events come from the data path
// Notes:   command start crosses by toggle; response words cross under a toggle handshake
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "card_cmd_map.svh"
module card_cmd_regs
(
    // core clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // fifo byte events from the data path, core clock; bus width select
    input  wire logic        RX_BYTE_IN,
    input  wire logic        RX_BYTE_OUT,
    input  wire logic        TX_BYTE_IN,
    input  wire logic        TX_BYTE_OUT,
    input  wire logic        WIDE_BUS,
    // card link
    input  wire logic        LINK_CLK,
    input  wire logic        CMD_IN,
    output logic             CMD_OUT,
    output logic             CMD_OE,
    input  wire logic        CARD_DATA_LINE_ONE,
    output logic             CARD_IRQ
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff, rst_n_ff;
    always_ff @(posedge CORE_CLK or negedge ARST_N)
        if (!ARST_N)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end

    logic lrst_meta_ff, lrst_n_ff;
    always_ff @(posedge LINK_CLK or negedge ARST_N)
        if (!ARST_N)
        begin
            lrst_meta_ff <= 1'b0;
            lrst_n_ff    <= 1'b0;
        end
        else
        begin
            lrst_meta_ff <= 1'b1;
            lrst_n_ff    <= lrst_meta_ff;
        end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_en, rd_en;
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && PENABLE && !PWRITE;
    assign PREADY  = 1'b1;

    logic [31:0] argument_ff;
    logic [10:0] command_ff;
    logic        start_tgl_ff;
    logic [5:0]  resp_index_ff;
    logic [31:0] resp_word_ff [4];
    logic [7:0]  rx_count_ff, tx_free_ff;
    logic        link_busy;

    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            argument_ff <= 32'h0000_0000;
        else if (wr_en && PADDR == `OFS_ARGUMENT)
            argument_ff <= PWDATA;

    // a command write while the link is busy still updates readback but starts nothing
    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
        begin
            command_ff   <= 11'h000;
            start_tgl_ff <= 1'b0;
        end
        else if (wr_en && PADDR == `OFS_COMMAND)
        begin
            command_ff <= PWDATA[`CMD_RTYPE_MSB:0];
            if (!link_busy)
                start_tgl_ff <= ~start_tgl_ff;
        end

    // ------------------------------------------------------------
    // fifo level counters
    // ------------------------------------------------------------
    logic rx_purge, tx_purge;
    assign rx_purge = wr_en && PADDR == `OFS_QUEUE_STATE && PWDATA[`RX_PURGE_BIT];
    assign tx_purge = wr_en && PADDR == `OFS_QUEUE_STATE && PWDATA[`TX_PURGE_BIT];

    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            rx_count_ff <= 8'h00;
        else if (rx_purge)
            rx_count_ff <= 8'h00;
        else if (RX_BYTE_IN && !RX_BYTE_OUT)
            rx_count_ff <= rx_count_ff + 8'h01;
        else if (RX_BYTE_OUT && !RX_BYTE_IN && rx_count_ff != 8'h00)
            rx_count_ff <= rx_count_ff - 8'h01;

    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            tx_free_ff <= `TX_FREE_RESET;
        else if (tx_purge)
            tx_free_ff <= `TX_FREE_RESET;
        else if (TX_BYTE_IN && !TX_BYTE_OUT && tx_free_ff != 8'h00)
            tx_free_ff <= tx_free_ff - 8'h01;
        else if (TX_BYTE_OUT && !TX_BYTE_IN && tx_free_ff != `TX_FREE_RESET)
            tx_free_ff <= tx_free_ff + 8'h01;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic        nxt_err;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        case (PADDR)
            `OFS_ARGUMENT:    nxt_rdata = argument_ff;
            `OFS_COMMAND:     nxt_rdata = {21'h0, command_ff[`CMD_RTYPE_MSB:`CMD_RTYPE_LSB], 1'b0,
                                           command_ff[`CMD_DATA_BIT:0]};
            `OFS_RESP_INDEX:  nxt_rdata = {26'h0, resp_index_ff};
            `OFS_RESP_WORD0:  nxt_rdata = resp_word_ff[0];
            `OFS_RESP_WORD1:  nxt_rdata = resp_word_ff[1];
            `OFS_RESP_WORD2:  nxt_rdata = resp_word_ff[2];
            `OFS_RESP_WORD3:  nxt_rdata = {8'h00, resp_word_ff[3][23:0]};
            `OFS_QUEUE_STATE: nxt_rdata = {16'h0, rx_count_ff, tx_free_ff};
            `OFS_LINK_STATUS: nxt_rdata = {31'h0, link_busy};
            default:          nxt_err   = 1'b1;
        endcase
    end
    // data output from flip-flops: captured during setup, valid in access
    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= nxt_rdata;
    assign PSLVERR = PSEL && PENABLE && nxt_err;

    // ------------------------------------------------------------
    // link domain: start toggle in, done toggle out
    // ------------------------------------------------------------
    logic [2:0]  lstart_sync_ff;
    logic        ldone_tgl_ff;
    logic [2:0]  done_sync_ff;
    logic        busy_ff;
    always_ff @(posedge LINK_CLK or negedge lrst_n_ff)
        if (!lrst_n_ff)
            lstart_sync_ff <= 3'h0;
        else
            lstart_sync_ff <= {lstart_sync_ff[1:0], start_tgl_ff};
    logic lstart;
    assign lstart = lstart_sync_ff[2] ^ lstart_sync_ff[1];

    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            done_sync_ff <= 3'h0;
        else
            done_sync_ff <= {done_sync_ff[1:0], ldone_tgl_ff};
    logic core_done;
    assign core_done = done_sync_ff[2] ^ done_sync_ff[1];

    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
            busy_ff <= 1'b0;
        else if (wr_en && PADDR == `OFS_COMMAND && !busy_ff)
            busy_ff <= 1'b1;
        else if (core_done)
            busy_ff <= 1'b0;
    assign link_busy = busy_ff;

    // command word is rewritten by a command write even while busy; the link reads it quasi-statically
    logic [2:0] rtype;
    logic       long_resp, short_resp;
    assign rtype      = command_ff[`CMD_RTYPE_MSB:`CMD_RTYPE_LSB];
    assign long_resp  = rtype == `RTYPE_R2;
    assign short_resp = rtype == `RTYPE_R1 || rtype == `RTYPE_R1B;

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    card_cmd_pkg::link_state_e state_ff;
    logic [47:0]  shift_ff;
    logic [135:0] rx_ff;
    logic [7:0]   bits_ff;
    logic [1:0]   cmd_in_sync_ff, d1_sync_ff, wide_sync_ff;
    logic         resp_got_ff;
    always_ff @(posedge LINK_CLK or negedge lrst_n_ff)
        if (!lrst_n_ff)
        begin
            cmd_in_sync_ff <= 2'b11;
            d1_sync_ff     <= 2'b11;
            wide_sync_ff   <= 2'b00;
        end
        else
        begin
            cmd_in_sync_ff <= {cmd_in_sync_ff[0], CMD_IN};
            d1_sync_ff     <= {d1_sync_ff[0], CARD_DATA_LINE_ONE};
            wide_sync_ff   <= {wide_sync_ff[0], WIDE_BUS};
        end
    logic cmd_in_s;
    assign cmd_in_s = cmd_in_sync_ff[1];

    always_ff @(posedge LINK_CLK or negedge lrst_n_ff)
        if (!lrst_n_ff)
        begin
            state_ff     <= card_cmd_pkg::LINK_IDLE;
            shift_ff     <= 48'h0000_0000_0000;
            rx_ff        <= '0;
            bits_ff      <= 8'h00;
            ldone_tgl_ff <= 1'b0;
            resp_got_ff  <= 1'b0;
        end
        else
            case (state_ff)
                card_cmd_pkg::LINK_IDLE:
                    if (lstart)
                    begin
                        // start, direction, index, argument, crc slot left zero, end bit
                        shift_ff <= {2'b01, command_ff[`CMD_INDEX_MSB:0], argument_ff, 8'h01};
                        bits_ff     <= `CMD_FRAME_BITS;
                        resp_got_ff <= 1'b0;
                        state_ff    <= card_cmd_pkg::LINK_SEND;
                    end
                card_cmd_pkg::LINK_SEND:
                begin
                    shift_ff <= {shift_ff[46:0], 1'b1};
                    bits_ff  <= bits_ff - 8'h01;
                    if (bits_ff == 8'h01)
                    begin
                        bits_ff  <= `RESP_WAIT_BITS;
                        state_ff <= card_cmd_pkg::LINK_WAIT;
                    end
                end
                card_cmd_pkg::LINK_WAIT:
                begin
                    bits_ff <= bits_ff - 8'h01;
                    rx_ff   <= '0;
                    if (!cmd_in_s)
                    begin
                        bits_ff  <= long_resp ? `LONG_FRAME_BITS - 8'h01 : `CMD_FRAME_BITS - 8'h01;
                        state_ff <= card_cmd_pkg::LINK_RECV;
                    end
                    else if (bits_ff == 8'h01)
                    begin
                        ldone_tgl_ff <= ~ldone_tgl_ff;      // no response: give up quietly
                        state_ff     <= card_cmd_pkg::LINK_IDLE;
                    end
                end
                card_cmd_pkg::LINK_RECV:
                begin
                    rx_ff   <= {rx_ff[134:0], cmd_in_s};
                    bits_ff <= bits_ff - 8'h01;
                    if (bits_ff == 8'h01)
                    begin
                        resp_got_ff  <= 1'b1;
                        bits_ff      <= `IRQ_WINDOW_BITS;
                        state_ff     <= card_cmd_pkg::LINK_IRQW;
                    end
                end
                card_cmd_pkg::LINK_IRQW:
                begin
                    bits_ff <= bits_ff - 8'h01;
                    // done only once idle again, so busy also covers the irq window
                    if (bits_ff == 8'h01)
                    begin
                        ldone_tgl_ff <= ~ldone_tgl_ff;
                        state_ff     <= card_cmd_pkg::LINK_IDLE;
                    end
                end
                default:
                    state_ff <= card_cmd_pkg::LINK_IDLE;
            endcase

    assign CMD_OUT = shift_ff[47];
    assign CMD_OE  = state_ff == card_cmd_pkg::LINK_SEND;

    // irq on line one only meaningful for non-data commands on a four-line bus
    logic irq_window;
    assign irq_window = state_ff == card_cmd_pkg::LINK_IRQW && wide_sync_ff[1] && !command_ff[`CMD_DATA_BIT];
    always_ff @(posedge LINK_CLK or negedge lrst_n_ff)
        if (!lrst_n_ff)
            CARD_IRQ <= 1'b0;
        else
            CARD_IRQ <= irq_window && !d1_sync_ff[1];

    // ------------------------------------------------------------
    // response capture, core side; link is idle, rx_ff and resp_got_ff hold until next start
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge rst_n_ff)
        if (!rst_n_ff)
        begin
            resp_index_ff   <= 6'h00;
            resp_word_ff[0] <= 32'h0000_0000;
            resp_word_ff[1] <= 32'h0000_0000;
            resp_word_ff[2] <= 32'h0000_0000;
            resp_word_ff[3] <= 32'h0000_0000;
        end
        else if (core_done && resp_got_ff)
        begin
            if (long_resp)
            begin
                resp_index_ff   <= `IDX_ALL_ONES;
                resp_word_ff[0] <= rx_ff[39:8];
                resp_word_ff[1] <= rx_ff[71:40];
                resp_word_ff[2] <= rx_ff[103:72];
                resp_word_ff[3] <= {8'h00, rx_ff[127:104]};
            end
            else
            begin
                resp_index_ff   <= short_resp ? rx_ff[45:40] : `IDX_ALL_ONES;
                resp_word_ff[0] <= rx_ff[39:8];
                resp_word_ff[1] <= 32'h0000_0000;
                resp_word_ff[2] <= 32'h0000_0000;
                resp_word_ff[3] <= 32'h0000_0000;
            end
        end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_rx_purge_zero: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        rx_purge |=> rx_count_ff == 8'h00) else $error("rx count not cleared by purge");
    chk_tx_purge_full: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        tx_purge |=> tx_free_ff == `TX_FREE_RESET) else $error("tx free not restored");
    chk_arg_readback: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        wr_en && PADDR == `OFS_ARGUMENT |=> argument_ff == $past(PWDATA)) else $error("arg lost");
    chk_cmd_readback: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        wr_en && PADDR == `OFS_COMMAND |=> command_ff[5:0] == $past(PWDATA[5:0]))
        else $error("index lost");
    chk_cmd_starts: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        wr_en && PADDR == `OFS_COMMAND && !busy_ff |=> start_tgl_ff != $past(start_tgl_ff))
        else $error("command did not start");
    chk_long_index: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        core_done && long_resp && resp_got_ff |=> resp_index_ff == `IDX_ALL_ONES)
        else $error("long index not ones");
    chk_short_words: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        core_done && short_resp && resp_got_ff |=> resp_word_ff[1] == 32'h0000_0000)
        else $error("short response filled word1");
    chk_word3_high: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        resp_word_ff[3][31:24] == 8'h00) else $error("word3 high bits set");
    chk_irq_window: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        CARD_IRQ |-> $past(irq_window)) else $error("irq outside window");
    chk_tx_free_max: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
        tx_free_ff <= `TX_FREE_RESET) else $error("tx free above empty value");
    cov_cmd_sent: cover property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        state_ff == card_cmd_pkg::LINK_SEND ##1 state_ff == card_cmd_pkg::LINK_WAIT);
    cov_resp_got: cover property (@(posedge CORE_CLK) disable iff (!rst_n_ff) core_done);
    cov_purge_busy: cover property (@(posedge CORE_CLK) disable iff (!rst_n_ff) rx_purge && RX_BYTE_IN);
endmodule : card_cmd_regs
